// ---- core/tpi_core.sv ----
// Page inventory read, fast page inventory read and surveillance arm/disarm handler.
// Assumes an RF framer delivering request bytes and a separate end-of-frame strobe.
`timescale 1ns/1ps
module tpi_core
  import tpi_pkg::*;
#(
  parameter int unsigned NUM_PAGES = 8,
  parameter logic [7:0]  MFG_CODE  = 8'h5a  // Arbitrary value
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_byte_i,
  input  wire logic        rx_eof_i,
  input  wire logic        rx_err_i,
  input  wire logic [3:0]  slot_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_byte_o,
  output logic             tx_last_o,
  input  wire logic        tx_ready_i,
  output logic             resp_fast_o,
  output logic             resp_high_rate_o,
  output logic             resp_dual_sub_o,
  output logic             resp_write_alike_o,
  output logic             resp_wait_eof_o,
  output logic             surv_mode_o
);
  localparam int         WORDS     = NUM_PAGES * WORDS_PER_PAGE;
  localparam int         WA        = $clog2(WORDS);
  localparam int         PG_AW     = $clog2(NUM_PAGES);
  localparam logic [7:0] LAST_PAGE = 8'(NUM_PAGES - 1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] bytes_of(input logic [7:0] bits);
    logic [8:0] t;
    t = {1'b0, bits} + 9'h007;
    return t[6:3];
  endfunction

  function automatic logic [63:0] low_ones(input logic [7:0] n);
    return (n >= UID_BITS_1SLOT) ? {64{1'b1}} : ((64'h1 << n) - 64'h1);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]           rxb_q [RXB_DEPTH];
  logic [4:0]           rx_cnt_q;
  tpi_state_t           st_q, st_d;
  logic [7:0]           pg_q, pg_d, last_pg_q;
  logic [3:0]           dix_q, dix_d, ub_q, ub_d;
  logic                 err_q, inv_q, uid_on_q;
  logic                 tx_valid_q, tx_last_q, last_d;
  logic [7:0]           tx_byte_q, byte_d;
  logic                 fast_q, hr_q, dual_q, wa_q, weof_q, surv_mode_q;
  logic [3:0]           ctrl_q;
  logic [63:0]          uid_q;
  logic [NUM_PAGES-1:0] prot_q;
  logic [7:0]           afi_q;
  logic [WA-1:0]        mem_addr_q;
  logic [31:0]          mem_q [WORDS];
  logic                 wb_ack_q;
  logic [31:0]          wb_dat_q;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  wire logic [7:0]  flg_w      = rxb_q[POS_FLAGS];
  wire logic [7:0]  cmd_w      = rxb_q[POS_CMD];
  wire logic        mfg_ok_w   = rxb_q[POS_MFG] == MFG_CODE;
  wire logic        afi_on_w   = flg_w[FLG_AFI];
  wire logic [3:0]  ml_pos_w   = afi_on_w ? POS_BODY + 4'h1 : POS_BODY;
  wire logic [7:0]  masklen_w  = rxb_q[ml_pos_w];
  wire logic [3:0]  mbytes_w   = bytes_of(masklen_w);
  wire logic [3:0]  mask_pos_w = ml_pos_w + 4'h1;
  wire logic [3:0]  first_pos  = mask_pos_w + mbytes_w;
  wire logic [7:0]  first_w    = rxb_q[first_pos];
  wire logic [7:0]  count_w    = rxb_q[first_pos + 4'h1];
  wire logic        sub16_w    = !flg_w[FLG_NB_SLOTS];
  wire logic [7:0]  ulim_w     = sub16_w ? UID_BITS_16SLOT : UID_BITS_1SLOT;
  wire logic        mlen_ok_w  = masklen_w <= ulim_w;
  wire logic        inv_len_ok = rx_cnt_q == (5'(ml_pos_w) + 5'(mbytes_w) + INV_TAIL);
  wire logic        inv_cmd_w  = (cmd_w == CMD_PAGE_INV) || (cmd_w == CMD_FAST_PAGE_INV);
  wire logic        fast_w     = cmd_w == CMD_FAST_PAGE_INV;
  wire logic        afi_ok_w   = !afi_on_w || (rxb_q[POS_BODY] == afi_q) ||
                                 (rxb_q[POS_BODY] == AFI_ANY);
  logic [63:0] mask_w;
  logic [7:0]  addr_eq_w;

  generate
    for (genvar g = 0; g < 8; g++) begin : g_bytes
      assign mask_w[8*g +: 8] = (4'(g) < mbytes_w) ? rxb_q[mask_pos_w + 4'(g)] : 8'h00;
      assign addr_eq_w[g]     = rxb_q[POS_BODY + 4'(g)] == uid_q[8*g +: 8];
    end
  endgenerate

  // Mask, plus slot number in 16-slot mode, compared against the low UID bits
  wire logic [63:0] target_w  = sub16_w ? {mask_w[59:0], slot_i} : mask_w;
  wire logic [7:0]  eff_len_w = masklen_w + (sub16_w ? SLOT_BITS : 8'h00);
  wire logic        match_w   = ((uid_q ^ target_w) & low_ones(eff_len_w)) == 64'h0;
  wire logic [8:0]  end_sum_w = {1'b0, first_w} + {1'b0, count_w};
  wire logic [7:0]  last_w    = (end_sum_w > {1'b0, LAST_PAGE}) ? LAST_PAGE : end_sum_w[7:0];
  wire logic [3:0]  ubytes_w  = bytes_of(ulim_w - masklen_w);
  wire logic [3:0]  ub_start  = UID_BYTES - ubytes_w;

  // Any failed check leaves the inventory reply out
  wire logic inv_ok_w = inv_cmd_w && flg_w[FLG_INVENTORY] && !flg_w[FLG_PROT_EXT] &&
                        mfg_ok_w && afi_ok_w && mlen_ok_w && inv_len_ok &&
                        (first_w <= LAST_PAGE) && match_w &&
                        !(fast_w && flg_w[FLG_SUBCARRIER]);

  wire logic       addressed_w = flg_w[FLG_ADDRESS];
  wire logic       addr_ok_w   = !addressed_w || (&addr_eq_w);
  wire logic [4:0] surv_len_w  = addressed_w ? 5'(POS_BODY) + 5'(UID_BYTES) : 5'(POS_BODY);
  wire logic       plain_w     = !flg_w[FLG_INVENTORY] && !flg_w[FLG_PROT_EXT] && mfg_ok_w;
  wire logic       arm_w       = cmd_w == CMD_SURV_ARM;
  wire logic       surv_cmd_w  = arm_w || (cmd_w == CMD_SURV_DISARM);
  // Option flag takes no part: both values accepted
  wire logic       surv_hit_w  = surv_cmd_w && plain_w && (rx_cnt_q == surv_len_w) &&
                                 addr_ok_w;
  wire logic       deny_w      = ctrl_q[CTRL_SURV_LOCK] ||
                                 (ctrl_q[CTRL_SURV_PROT] && !ctrl_q[CTRL_SURV_PW]);
  wire logic       unk_w       = !inv_cmd_w && !surv_cmd_w && plain_w && addressed_w &&
                                 (&addr_eq_w) && (rx_cnt_q >= surv_len_w);
  wire logic       err_w       = (surv_hit_w && deny_w) || unk_w;
  wire logic       eof_ok_w    = rx_eof_i && !rx_err_i && (st_q == S_IDLE) && !tx_valid_q;
  wire logic       go_w        = eof_ok_w && (inv_ok_w || surv_hit_w || unk_w);

  // ---------------------------------------------------------------
  // Reply sequencer
  // ---------------------------------------------------------------
  wire logic        ld_w       = (st_q != S_IDLE) && (!tx_valid_q || tx_ready_i);
  wire logic        locked_w   = prot_q[pg_q[PG_AW-1:0]] && !ctrl_q[CTRL_RD_PW];
  wire logic [31:0] page_word  = mem_q[{pg_q[PG_AW-1:0], dix_q[3:2]}];
  wire logic [7:0]  mem_byte_w = page_word[{dix_q[1:0], 3'h0} +: 8];
  wire logic [7:0]  uid_byte_w = uid_q[{ub_q[2:0], 3'h0} +: 8];

  always_comb begin
    st_d   = st_q;
    pg_d   = pg_q;
    dix_d  = dix_q;
    ub_d   = ub_q;
    byte_d = tx_byte_q;
    last_d = 1'b0;
    unique case (st_q)
      S_IDLE: begin
      end
      S_FLAGS: begin
        byte_d = err_q ? RSP_FLAGS_ERR : RSP_FLAGS_OK;
        if (err_q) begin
          st_d = S_ERR;
        end else if (!inv_q) begin
          last_d = 1'b1;
          st_d   = S_IDLE;
        end else if (uid_on_q && (ub_q != UID_BYTES)) begin
          st_d = S_UID;
        end else begin
          st_d = S_STAT;
        end
      end
      S_ERR: begin
        byte_d = ERR_CODE_GENERIC;
        last_d = 1'b1;
        st_d   = S_IDLE;
      end
      S_UID: begin
        byte_d = uid_byte_w;
        ub_d   = ub_q + 4'h1;
        if (ub_q == UID_BYTES - 4'h1) begin
          st_d = S_STAT;
        end
      end
      S_STAT: begin
        byte_d = locked_w ? STAT_LOCKED : STAT_OPEN;
        if (!locked_w) begin
          st_d  = S_DATA;
          dix_d = 4'h0;
        end else if (pg_q == last_pg_q) begin
          last_d = 1'b1;
          st_d   = S_IDLE;
        end else begin
          pg_d = pg_q + 8'h01;
        end
      end
      S_DATA: begin
        byte_d = mem_byte_w;
        dix_d  = dix_q + 4'h1;
        if (dix_q == PAGE_LAST_BYTE) begin
          if (pg_q == last_pg_q) begin
            last_d = 1'b1;
            st_d   = S_IDLE;
          end else begin
            pg_d = pg_q + 8'h01;
            st_d = S_STAT;
          end
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q      <= S_IDLE;
      pg_q      <= 8'h00;
      last_pg_q <= 8'h00;
      dix_q     <= 4'h0;
      ub_q      <= 4'h0;
      err_q     <= 1'b0;
      inv_q     <= 1'b0;
      uid_on_q  <= 1'b0;
    end else if (go_w) begin
      st_q      <= S_FLAGS;
      pg_q      <= first_w;
      last_pg_q <= last_w;
      dix_q     <= 4'h0;
      ub_q      <= ub_start;
      err_q     <= err_w;
      inv_q     <= inv_ok_w;
      uid_on_q  <= inv_ok_w && flg_w[FLG_OPTION];
    end else if (ld_w) begin
      st_q  <= st_d;
      pg_q  <= pg_d;
      dix_q <= dix_d;
      ub_q  <= ub_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_q <= 1'b0;
      tx_byte_q  <= 8'h00;
      tx_last_q  <= 1'b0;
    end else if (ld_w) begin
      tx_valid_q <= 1'b1;
      tx_byte_q  <= byte_d;
      tx_last_q  <= last_d;
    end else if (tx_ready_i) begin
      tx_valid_q <= 1'b0;
    end
  end

  // Link settings handed to the framer for this reply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_q <= 1'b0;
      hr_q   <= 1'b0;
      dual_q <= 1'b0;
      wa_q   <= 1'b0;
      weof_q <= 1'b0;
    end else if (go_w) begin
      fast_q <= inv_ok_w && fast_w;
      hr_q   <= flg_w[FLG_HIGH_RATE];
      dual_q <= flg_w[FLG_SUBCARRIER] && !fast_w;
      wa_q   <= surv_hit_w;
      weof_q <= surv_hit_w && flg_w[FLG_OPTION];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      surv_mode_q <= 1'b0;
    end else if (go_w && surv_hit_w && !deny_w) begin
      surv_mode_q <= arm_w;
    end
  end

  // ---------------------------------------------------------------
  // Request capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_q <= 5'h00;
      for (int i = 0; i < RXB_DEPTH; i++) begin
        rxb_q[i] <= 8'h00;
      end
    end else if (rx_eof_i) begin
      rx_cnt_q <= 5'h00;
    end else if (rx_valid_i && (st_q == S_IDLE) && !tx_valid_q && (rx_cnt_q != RX_CNT_MAX)) begin
      rx_cnt_q <= rx_cnt_q + 5'h01;
      if (rx_cnt_q < 5'(RXB_DEPTH)) begin
        rxb_q[rx_cnt_q[3:0]] <= rx_byte_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  wire logic        wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_q;
  wire logic        wb_wr_w  = wb_req_w && wb_we_i;
  wire logic        mem_hit  = wb_adr_i == REG_MEM_DATA;
  wire logic [31:0] rd_mux_w =
    (wb_adr_i == REG_CTRL)     ? 32'(ctrl_q) :
    (wb_adr_i == REG_STATUS)   ? 32'({st_q, surv_mode_q}) :
    (wb_adr_i == REG_UID_LO)   ? uid_q[31:0] :
    (wb_adr_i == REG_UID_HI)   ? uid_q[63:32] :
    (wb_adr_i == REG_PROT)     ? 32'(prot_q) :
    (wb_adr_i == REG_MEM_ADDR) ? 32'(mem_addr_q) :
    mem_hit                    ? mem_q[mem_addr_q] :
    (wb_adr_i == REG_AFI)      ? 32'(afi_q) : 32'h0000_0000;
  wire logic [31:0] wr_w     = merge(rd_mux_w, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q   <= 1'b0;
      wb_dat_q   <= 32'h0000_0000;
      ctrl_q     <= CTRL_RST;
      uid_q      <= 64'h0;
      prot_q     <= '0;
      afi_q      <= AFI_RST;
      mem_addr_q <= '0;
    end else begin
      wb_ack_q <= wb_req_w;
      if (wb_req_w) begin
        wb_dat_q <= wb_we_i ? 32'h0000_0000 : rd_mux_w;
      end
      if (wb_wr_w && (wb_adr_i == REG_CTRL)) begin
        ctrl_q <= wr_w[3:0];
      end
      if (wb_wr_w && (wb_adr_i == REG_UID_LO)) begin
        uid_q[31:0] <= wr_w;
      end
      if (wb_wr_w && (wb_adr_i == REG_UID_HI)) begin
        uid_q[63:32] <= wr_w;
      end
      if (wb_wr_w && (wb_adr_i == REG_PROT)) begin
        prot_q <= wr_w[NUM_PAGES-1:0];
      end
      if (wb_wr_w && (wb_adr_i == REG_AFI)) begin
        afi_q <= wr_w[7:0];
      end
      if (wb_wr_w && (wb_adr_i == REG_MEM_ADDR)) begin
        mem_addr_q <= wr_w[WA-1:0];
      end else if (wb_req_w && mem_hit) begin
        mem_addr_q <= mem_addr_q + WA'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wb_wr_w && mem_hit) begin
      mem_q[mem_addr_q] <= wr_w;
    end
  end

  assign wb_ack_o           = wb_ack_q;
  assign wb_dat_o           = wb_dat_q;
  assign tx_valid_o         = tx_valid_q;
  assign tx_byte_o          = tx_byte_q;
  assign tx_last_o          = tx_last_q;
  assign resp_fast_o        = fast_q;
  assign resp_high_rate_o   = hr_q;
  assign resp_dual_sub_o    = dual_q;
  assign resp_write_alike_o = wa_q;
  assign resp_wait_eof_o    = weof_q;
  assign surv_mode_o        = surv_mode_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_open_stat;
    ld_w && (st_q == S_STAT) && !locked_w;
  endsequence
  sequence s_locked_stat;
    ld_w && (st_q == S_STAT) && locked_w;
  endsequence
  sequence s_err_frame;
    (st_q == S_FLAGS) ##1 (st_q == S_ERR && tx_valid_o && tx_byte_o == RSP_FLAGS_ERR);
  endsequence

  AST_SILENT_ERR: assert property (rx_eof_i && rx_err_i |=> st_q == S_IDLE)
    else $error("reply started after a bad frame");
  AST_OPEN_PAGE: assert property (s_open_stat |=> tx_byte_o == STAT_OPEN && st_q == S_DATA)
    else $error("open page status or data missing");
  AST_LOCKED_PAGE: assert property (s_locked_stat |=> tx_byte_o == STAT_LOCKED
                                    && st_q != S_DATA)
    else $error("locked page status wrong or data sent");
  AST_PAGE_LIMIT: assert property (st_q == S_DATA |-> pg_q <= LAST_PAGE)
    else $error("page beyond last user page");
  AST_LAST_BOUND: assert property (ld_w && last_d && (st_q == S_DATA || st_q == S_STAT)
                                   |-> pg_q == last_pg_q)
    else $error("reply ended on wrong page");
  AST_FAST_SINGLE: assert property (resp_fast_o |-> !resp_dual_sub_o)
    else $error("fast reply on dual subcarrier");
  AST_ARM: assert property (go_w && surv_hit_w && arm_w && !deny_w |=> surv_mode_o)
    else $error("arm did not enable surveillance");
  AST_LOCK_HOLD: assert property (ctrl_q[CTRL_SURV_LOCK] && $past(ctrl_q[CTRL_SURV_LOCK])
                                  |-> $stable(surv_mode_q))
    else $error("surveillance mode changed while locked");
  AST_ERR_REPLY: assert property (go_w && err_w |=> s_err_frame)
    else $error("error code not sent");
  AST_INV_SILENT: assert property (eof_ok_w && flg_w[FLG_INVENTORY] && !inv_ok_w
                                   |=> st_q == S_IDLE)
    else $error("reply to unsupported inventory request");
endmodule

// ---- core/tpi_pkg.sv ----
// Constants, types and register map of the page inventory and surveillance handler.
// Assumes a framer that strips SOF, CRC and EOF on receive and adds them on transmit.
package tpi_pkg;
  // ---------------------------------------------------------------
  // Command codes and request layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE_INV      = 8'hb0;
  localparam logic [7:0] CMD_FAST_PAGE_INV = 8'hb1;
  localparam logic [7:0] CMD_SURV_ARM      = 8'ha2;
  localparam logic [7:0] CMD_SURV_DISARM   = 8'ha3;
  localparam int         FLG_SUBCARRIER    = 0;
  localparam int         FLG_HIGH_RATE     = 1;
  localparam int         FLG_INVENTORY     = 2;
  localparam int         FLG_PROT_EXT      = 3;
  localparam int         FLG_AFI           = 4;
  localparam int         FLG_NB_SLOTS      = 5;
  localparam int         FLG_ADDRESS       = 5;
  localparam int         FLG_OPTION        = 6;
  localparam logic [3:0] POS_FLAGS         = 4'h0;
  localparam logic [3:0] POS_CMD           = 4'h1;
  localparam logic [3:0] POS_MFG           = 4'h2;
  localparam logic [3:0] POS_BODY          = 4'h3;
  localparam logic [3:0] UID_BYTES         = 4'h8;
  localparam logic [4:0] INV_TAIL          = 5'h3;
  localparam logic [7:0] AFI_ANY           = 8'h00;
  localparam logic [7:0] UID_BITS_16SLOT   = 8'h3c;
  localparam logic [7:0] UID_BITS_1SLOT    = 8'h40;
  localparam logic [7:0] SLOT_BITS         = 8'h04;
  localparam int         RXB_DEPTH         = 16;
  localparam logic [4:0] RX_CNT_MAX        = 5'h1f;
  localparam int         WORDS_PER_PAGE    = 4;
  localparam logic [3:0] PAGE_LAST_BYTE    = 4'hf;
  // ---------------------------------------------------------------
  // Reply bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] RSP_FLAGS_OK      = 8'h00;
  localparam logic [7:0] RSP_FLAGS_ERR     = 8'h01;
  localparam logic [7:0] ERR_CODE_GENERIC  = 8'h0f;
  localparam logic [7:0] STAT_OPEN         = 8'h00;
  localparam logic [7:0] STAT_LOCKED       = 8'h0f;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL          = 8'h00;
  localparam logic [7:0] REG_STATUS        = 8'h04;
  localparam logic [7:0] REG_UID_LO        = 8'h08;
  localparam logic [7:0] REG_UID_HI        = 8'h0c;
  localparam logic [7:0] REG_PROT          = 8'h10;
  localparam logic [7:0] REG_MEM_ADDR      = 8'h14;
  localparam logic [7:0] REG_MEM_DATA      = 8'h18;
  localparam logic [7:0] REG_AFI           = 8'h1c;
  localparam int         CTRL_RD_PW        = 0;
  localparam int         CTRL_SURV_LOCK    = 1;
  localparam int         CTRL_SURV_PROT    = 2;
  localparam int         CTRL_SURV_PW      = 3;
  localparam logic [3:0] CTRL_RST          = 4'h0;
  localparam logic [7:0] AFI_RST           = 8'h00;
  // ---------------------------------------------------------------
  // Reply sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_FLAGS = 6'h02,
    S_ERR   = 6'h04,
    S_UID   = 6'h08,
    S_STAT  = 6'h10,
    S_DATA  = 6'h20
  } tpi_state_t;
endpackage

// ---- verif/tpi_reader.sv ----
// Reader model: sends request bytes, takes reply bytes with random stalls.
// Assumes the handler's byte stream ports on the same clock.
`timescale 1ns/1ps
module tpi_reader (
  input  wire logic       clk_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_last_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_byte_o,
  output logic            rx_eof_o,
  output logic            rx_err_o,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  logic       done;
  initial begin
    {rx_valid_o, rx_eof_o, rx_err_o} = 3'h0;
    rx_byte_o = 8'h00;
    done = 1'b0;
  end
  // Bytes in caller order, count field already minus one
  task automatic send(input logic [7:0] q[$], input logic err);
    got.delete();
    done = 1'b0;
    foreach (q[i]) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o <= q[i];
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_byte_o <= ~q[i];
    end
    @(posedge clk_i);
    rx_eof_o <= 1'b1;
    rx_err_o <= err;
    @(posedge clk_i);
    rx_eof_o <= 1'b0;
    rx_err_o <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_byte_i);
      if (tx_last_i) done <= 1'b1;
    end
    tx_ready_o <= 1'($urandom % 2);
  end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the page inventory and surveillance handler.
// Assumes tpi_pkg, tpi_core and the reader model tpi_reader.
`timescale 1ns/1ps
module testbench;
  import tpi_pkg::*;
  localparam int         NP  = 8;
  localparam logic [7:0] MFG = 8'h5a;  // Arbitrary value
  logic        clk_i, rst_i, cyc, we, ack, rv, eof, rerr, rdy, tv, tl, rpw;
  logic        fast, hr, dual, wal, weof, surv, ok, sv;
  logic [7:0]  adr, rb, tb, prot;
  logic [31:0] wdat, rdat, dat_o;
  logic [3:0]  slot;
  logic [63:0] uid;
  logic [31:0] mem[NP*4];
  logic [7:0]  req[$], exq[$];
  logic [3:0]  sc_ctrl[7] = '{4'h0, 4'h2, 4'h4, 4'hc, 4'h2, 4'h0, 4'h0};
  logic [7:0]  sc_cmd[7] = '{8'ha2, 8'ha3, 8'ha3, 8'ha3, 8'ha2, 8'ha2, 8'ha0};
  logic [7:0]  sc_fl[7] = '{8'h00, 8'h40, 8'h00, 8'h40, 8'h00, 8'h60, 8'h20};
  int          error_cnt, comparisons, mode;
  tpi_core #(.NUM_PAGES(NP), .MFG_CODE(MFG)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_valid_i(rv), .rx_byte_i(rb), .rx_eof_i(eof),
    .rx_err_i(rerr), .slot_i(slot), .tx_valid_o(tv), .tx_byte_o(tb), .tx_last_o(tl),
    .tx_ready_i(rdy), .resp_fast_o(fast), .resp_high_rate_o(hr), .resp_dual_sub_o(dual),
    .resp_write_alike_o(wal), .resp_wait_eof_o(weof), .surv_mode_o(surv));
  tpi_reader rdr (.clk_i, .tx_valid_i(tv), .tx_byte_i(tb), .tx_last_i(tl), .rx_valid_o(rv),
    .rx_byte_o(rb), .rx_eof_o(eof), .rx_err_o(rerr), .tx_ready_o(rdy));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      chk("wb timeout", 0, 1);
      stop_test();
    end
    rdat = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic run(input logic err);
    int n;
    rdr.send(req, err);
    n = 0;
    while (rdr.done !== 1'b1 && n < (exq.size() > 0 ? 800 : 60)) begin
      @(posedge clk_i);
      n++;
    end
    if (exq.size() > 0 && rdr.done !== 1'b1) begin
      chk("reply timeout", 0, 1);
      stop_test();
    end
    chk("reply length", exq.size(), rdr.got.size());
    foreach (exq[i]) chk("reply byte", exq[i], rdr.got[i]);
    @(posedge clk_i);
  endtask
  task automatic inv(input logic [7:0] fl, cmd, ml, first, cnt, input logic sil, err);
    int nu;
    req = {fl, cmd, MFG};
    if (fl[4]) req.push_back(8'h00);
    req.push_back(ml);
    if (ml != 0) req.push_back(fl[5] ? {4'h0, uid[3:0]} : {4'h0, uid[7:4]});
    req.push_back(first);
    req.push_back(cnt);
    exq = {8'h00};
    nu = ((fl[5] ? 64 : 60) - ml + 7) / 8;
    if (fl[6]) for (int i = 8 - nu; i < 8; i++) exq.push_back(uid[8*i +: 8]);
    for (int p = first; p <= first + cnt && p < NP; p++) begin
      exq.push_back((prot[p] && !rpw) ? 8'h0f : 8'h00);
      if (!prot[p] || rpw) for (int b = 0; b < 16; b++) exq.push_back(mem[p*4+b/4][8*(b%4) +: 8]);
    end
    if (sil) exq.delete();
    run(err);
  endtask
  initial begin
    {cyc, we, rst_i, rpw, adr, wdat, slot} = '0;
    rst_i = 1'b1;
    {error_cnt, comparisons, mode} = '0;
    prot = 8'h80;
    void'($urandom(32'h1d4dfa8e));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("surv reset", 0, surv);
    wb(0, REG_CTRL, 0);
    chk("ctrl reset", 0, rdat);
    wb(0, 8'h40, 0);
    chk("unmapped", 0, rdat);
    uid = {$urandom, $urandom};
    wb(1, REG_UID_LO, uid[31:0]);
    wb(1, REG_UID_HI, uid[63:32]);
    wb(1, REG_PROT, {24'h0, prot});
    wb(1, REG_MEM_ADDR, 24);
    for (int i = 24; i < 32; i++) begin
      mem[i] = $urandom;
      wb(1, REG_MEM_DATA, mem[i]);
    end
    wb(1, REG_MEM_ADDR, 29);
    wb(0, REG_MEM_DATA, 0);
    chk("mem read", mem[29], rdat);
    slot <= uid[3:0];
    inv(8'h24, CMD_PAGE_INV, 0, 6, 3, 0, 0);
    inv(8'h64, CMD_PAGE_INV, 4, 7, 0, 0, 0);
    inv(8'h44, CMD_PAGE_INV, 4, 6, 0, 0, 0);
    inv(8'h35, CMD_PAGE_INV, 0, 7, 0, 0, 0);
    chk("dual sub", 1, dual);
    wb(1, REG_CTRL, 1);
    rpw = 1'b1;
    inv(8'h26, CMD_FAST_PAGE_INV, 0, 7, 0, 0, 0);
    chk("fast", 1, fast);
    chk("high rate", 1, hr);
    chk("dual sub", 0, dual);
    inv(8'h25, CMD_FAST_PAGE_INV, 0, 7, 0, 1, 0);
    inv(8'h24, CMD_PAGE_INV, 0, 6, 0, 1, 1);
    inv(8'h24, 8'ha0, 0, 6, 0, 1, 0);
    inv(8'h24, CMD_PAGE_INV, 0, 8, 0, 1, 0);
    for (int i = 0; i < 7; i++) begin
      wb(1, REG_CTRL, {28'h0, sc_ctrl[i]});
      req = {sc_fl[i], sc_cmd[i], MFG};
      if (sc_fl[i][5]) for (int b = 0; b < 8; b++) req.push_back(uid[8*b +: 8]);
      sv = (sc_cmd[i] == CMD_SURV_ARM) || (sc_cmd[i] == CMD_SURV_DISARM);
      ok = sv && !sc_ctrl[i][1] && !(sc_ctrl[i][2] && !sc_ctrl[i][3]);
      if (ok) mode = int'(sc_cmd[i] == CMD_SURV_ARM);
      exq = {8'h00};
      if (!ok) exq = {8'h01, 8'h0f};
      run(0);
      chk("surv mode", mode, surv);
      chk("wait eof", sc_fl[i][6] && sv, weof);
      chk("write alike", sv, wal);
    end
    stop_test();
  end
endmodule
